/* rtl/bfsc_pkg.sv */
// package: constants and state encoding for the buck fault shutdown control
package bfsc_pkg;

	// clock and timing figures in nanoseconds
	localparam int CLK_PERIOD_NS = 40;
	localparam int BLANK_NS = 160;
	localparam int MIN_ON_NS = 50;
	localparam int OFF_NS = 200;

	// least times round up to whole clock cycles
	localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_ON_CYC = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OFF_CYC = (OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// switching cycles the soft-start node is held low in hiccup
	localparam int HICCUP_CYCLES = 4096;

	// width of the short pulse timers
	localparam int TMR_W = 4;
	localparam logic [TMR_W-1:0] TMR_ZERO = 4'h0;
	localparam logic [TMR_W-1:0] BLANK_CNT = TMR_W'(BLANK_CYC);
	localparam logic [TMR_W-1:0] MIN_ON_CNT = TMR_W'(MIN_ON_CYC);
	localparam logic [TMR_W-1:0] OFF_CNT = TMR_W'(OFF_CYC);

	// bit positions in the synchronised comparator vector
	localparam int IN_W = 10;
	localparam int IN_SUPPLY_OK = 0;
	localparam int IN_ENABLE_OK = 1;
	localparam int IN_SS_LOW = 2;
	localparam int IN_SS_FULL = 3;
	localparam int IN_OC_BELOW_GND = 4;
	localparam int IN_OVER_TEMP = 5;
	localparam int IN_TRACK_HIGH = 6;
	localparam int IN_FB_GOOD = 7;
	localparam int IN_PWM_DEMAND = 8;
	localparam int IN_OSC = 9;

	// controller states
	typedef enum logic [2:0] {
		ST_OFF,
		ST_PREBIAS,
		ST_RUN,
		ST_SS_SHUT,
		ST_SS_WAIT,
		ST_HICCUP,
		ST_THERMAL
	} bfsc_state_type;

endpackage : bfsc_pkg

/* rtl/bfsc_sync.sv */
// module: two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns
module bfsc_sync
#(
	parameter int W = 1
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	// both stages in one state word
	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
	} bfsc_sync_type;

	bfsc_sync_type s_r;
	bfsc_sync_type s_nxt;

	// first stage only feeds the second
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.stage1 = async_in;
		s_nxt.stage2 = s_r.stage1;
	end

	// register the state word
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign sync_out = s_r.stage2;

endmodule : bfsc_sync

/* rtl/bfsc_ctrl.sv */
// module: supervisory and protection controller of a synchronous buck stage
//
// What this block does
// R1 - enable low tristates both gate drives
// R2 - soft-start low: high off, low on
// R3 - resume after soft-start released and recharged
// R4 - overcurrent when sense below ground, low on
// R5 - overcurrent latches fault and starts hiccup
// R6 - hiccup grounds soft-start, counts cycles, clears
// R7 - hiccup repeats while overcurrent persists
// R8 - ignore current sense during blanking after low-on
// R9 - over-temperature turns switches off, discharges soft-start
// R10 - restart automatically when over-temperature clears
// R11 - reference follows tracking input until hand-over
// R12 - output good once feedback reaches threshold
// R13 - output good is open-drain, low when bad
// R14 - no high-side pulse below minimum on-time
// R15 - fixed off-time in every switching cycle
// R16 - soft-start begins only with supply valid
// R17 - low side off until first high pulse
// R18 - supply invalid clears fault, counter, drives
// R19 - enable-low beats thermal beats hiccup beats run
`timescale 1ns/1ns
module bfsc_ctrl
	import bfsc_pkg::*;
#(
	parameter int HICCUP_LEN = HICCUP_CYCLES,
	parameter int HIC_W = 13
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// comparator and status levels from the analog side
	input wire logic supply_ok,
	input wire logic enable_ok,
	input wire logic ss_low,
	input wire logic ss_full,
	input wire logic oc_below_gnd,
	input wire logic over_temp,
	input wire logic track_high,
	input wire logic fb_good,
	// modulator demand and switching oscillator
	input wire logic pwm_demand,
	input wire logic osc,
	// high-side gate drive
	output logic hs_on,
	output logic hs_oe,
	// low-side gate drive
	output logic ls_on,
	output logic ls_oe,
	// soft-start discharge switch and reference select
	output logic ss_discharge,
	output logic ref_internal,
	// latched fault flag
	output logic overcurrent_fault,
	// open-drain output good pin
	input wire logic output_good_in,
	output logic output_good_out,
	output logic output_good_oe
);

	// whole controller state
	typedef struct packed {
		bfsc_state_type st;
		logic osc_prev;
		logic first_hs;
		logic [TMR_W-1:0] on_tmr;
		logic [TMR_W-1:0] off_tmr;
		logic [TMR_W-1:0] blank_tmr;
		logic [HIC_W-1:0] hic_cnt;
		logic hs_on;
		logic hs_oe;
		logic ls_on;
		logic ls_oe;
		logic ss_dis;
		logic ref_int;
		logic oc_fault;
		logic pg_oe;
	} bfsc_ctrl_type;

	localparam logic [HIC_W-1:0] HIC_LAST = HIC_W'(HICCUP_LEN - 1);

	bfsc_ctrl_type s_r;
	bfsc_ctrl_type s_nxt;
	logic [IN_W-1:0] raw_in; // comparator levels before crossing
	logic [IN_W-1:0] in_s; // comparator levels after crossing
	logic osc_tick; // one clock at each switching-cycle start
	logic oc_seen; // qualified overcurrent sample

	// gather the asynchronous inputs
	always_comb
	begin
		raw_in = '0;
		raw_in[IN_SUPPLY_OK] = supply_ok;
		raw_in[IN_ENABLE_OK] = enable_ok;
		raw_in[IN_SS_LOW] = ss_low;
		raw_in[IN_SS_FULL] = ss_full;
		raw_in[IN_OC_BELOW_GND] = oc_below_gnd;
		raw_in[IN_OVER_TEMP] = over_temp;
		raw_in[IN_TRACK_HIGH] = track_high;
		raw_in[IN_FB_GOOD] = fb_good;
		raw_in[IN_PWM_DEMAND] = pwm_demand;
		raw_in[IN_OSC] = osc;
	end

	// every comparator crosses two flip-flops first
	bfsc_sync #(
		.W(IN_W)
	) u_sync (
		.clk(clk),
		.rstn(rstn),
		.async_in(raw_in),
		.sync_out(in_s)
	);

	// rising edge of the synchronised oscillator
	assign osc_tick = in_s[IN_OSC] & ~s_r.osc_prev;

	// current sense only counts after blanking with low side on
	assign oc_seen = in_s[IN_OC_BELOW_GND] & s_r.ls_on & s_r.ls_oe
		& (s_r.blank_tmr == BLANK_CNT); // R4 R8

	// next-state logic
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.osc_prev = in_s[IN_OSC];
		s_nxt.ref_int = in_s[IN_TRACK_HIGH]; // R11
		// short timers count up and saturate
		if (s_r.on_tmr != MIN_ON_CNT)
		begin
			s_nxt.on_tmr = s_r.on_tmr + 4'h1;
		end
		if (s_r.off_tmr != OFF_CNT)
		begin
			s_nxt.off_tmr = s_r.off_tmr + 4'h1;
		end
		// blanking restarts whenever low side is not conducting
		if (!(s_r.ls_on && s_r.ls_oe))
		begin
			s_nxt.blank_tmr = TMR_ZERO; // R8
		end
		else if (s_r.blank_tmr != BLANK_CNT)
		begin
			s_nxt.blank_tmr = s_r.blank_tmr + 4'h1; // R8
		end

		if (!in_s[IN_ENABLE_OK] || !in_s[IN_SUPPLY_OK])
		begin
			// enable or supply lost: everything off, highest priority
			s_nxt.st = ST_OFF; // R19
		end
		else if (in_s[IN_OVER_TEMP] && s_r.st != ST_OFF)
		begin
			// thermal trip overrides hiccup and switching
			s_nxt.st = ST_THERMAL; // R9 R19
			// an abandoned hiccup must not leave the fault latched on restart
			s_nxt.oc_fault = 1'b0;
			s_nxt.hic_cnt = '0;
		end
		else
		begin
			unique case (s_r.st)
				// waiting for supply valid to start soft-start
				ST_OFF:
				begin
					s_nxt.st = ST_PREBIAS; // R16
					s_nxt.first_hs = 1'b0;
				end
				// switching states
				ST_PREBIAS, ST_RUN:
				begin
					if (oc_seen)
					begin
						s_nxt.st = ST_HICCUP; // R5
						s_nxt.oc_fault = 1'b1; // R5
						s_nxt.hic_cnt = '0;
					end
					else if (in_s[IN_SS_LOW])
					begin
						s_nxt.st = ST_SS_SHUT; // R2
					end
					else if (s_r.first_hs)
					begin
						s_nxt.st = ST_RUN; // R17
					end
				end
				// soft-start pulled down externally
				ST_SS_SHUT:
				begin
					if (!in_s[IN_SS_LOW])
					begin
						s_nxt.st = ST_SS_WAIT; // R3
					end
				end
				// released: wait for soft-start to charge again
				ST_SS_WAIT:
				begin
					if (in_s[IN_SS_LOW])
					begin
						s_nxt.st = ST_SS_SHUT; // R2
					end
					else if (in_s[IN_SS_FULL])
					begin
						s_nxt.st = ST_PREBIAS; // R3
						s_nxt.first_hs = 1'b0;
					end
				end
				// hiccup: count switching cycles with soft-start low
				ST_HICCUP:
				begin
					if (osc_tick)
					begin
						if (s_r.hic_cnt == HIC_LAST)
						begin
							s_nxt.oc_fault = 1'b0; // R6
							s_nxt.st = ST_PREBIAS; // R6 R7
							s_nxt.first_hs = 1'b0;
						end
						else
						begin
							s_nxt.hic_cnt = s_r.hic_cnt + 1'b1; // R6
						end
					end
				end
				// over-temperature has cleared: restart
				ST_THERMAL:
				begin
					s_nxt.st = ST_PREBIAS; // R10
					s_nxt.first_hs = 1'b0;
				end
			endcase
		end

		// supply loss clears fault and hiccup count
		if (!in_s[IN_SUPPLY_OK])
		begin
			s_nxt.oc_fault = 1'b0; // R18
			s_nxt.hic_cnt = '0; // R18
		end

		// gate drive for the state being entered
		s_nxt.hs_oe = 1'b1;
		s_nxt.ls_oe = 1'b1;
		s_nxt.ss_dis = 1'b0;
		s_nxt.hs_on = 1'b0;
		s_nxt.ls_on = 1'b0;
		unique case (s_nxt.st)
			// drivers tristated, soft-start held low
			ST_OFF:
			begin
				s_nxt.hs_oe = 1'b0; // R1 R18
				s_nxt.ls_oe = 1'b0; // R1 R18
				s_nxt.ss_dis = 1'b1;
			end
			// active discharge through the low side
			ST_SS_SHUT:
			begin
				s_nxt.ls_on = 1'b1; // R2
			end
			// both switches off while soft-start recharges
			ST_SS_WAIT:
			begin
				s_nxt.ls_on = 1'b0; // R3
			end
			// soft-start grounded, switches off
			ST_HICCUP, ST_THERMAL:
			begin
				s_nxt.ss_dis = 1'b1; // R6 R9
			end
			// normal pulse shaping
			ST_PREBIAS, ST_RUN:
			begin
				if (s_r.hs_on && s_r.hs_oe)
				begin
					// end pulse on demand drop or cycle end, never short
					if (s_r.on_tmr != MIN_ON_CNT)
					begin
						s_nxt.hs_on = 1'b1; // R14
					end
					else if (in_s[IN_PWM_DEMAND] && !osc_tick)
					begin
						s_nxt.hs_on = 1'b1; // R15
					end
				end
				else if (in_s[IN_PWM_DEMAND] && s_r.off_tmr == OFF_CNT)
				begin
					// start pulse only after the full off-time
					s_nxt.hs_on = 1'b1; // R15
					s_nxt.on_tmr = TMR_ZERO; // R14
					s_nxt.first_hs = 1'b1; // R17
				end
				// low side follows high side once a pulse has been seen
				s_nxt.ls_on = ~s_nxt.hs_on & s_nxt.first_hs; // R17
			end
		endcase
		// off-time restarts as the high side switches off
		if (s_r.hs_on && !s_nxt.hs_on)
		begin
			s_nxt.off_tmr = TMR_ZERO; // R15
		end

		// output good only while switching with feedback in range
		s_nxt.pg_oe = ~(in_s[IN_FB_GOOD]
			& ((s_nxt.st == ST_RUN) | (s_nxt.st == ST_PREBIAS))); // R12 R13
	end

	// register the state word
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_r.st <= ST_OFF;
			s_r.osc_prev <= 1'b0;
			s_r.first_hs <= 1'b0;
			s_r.on_tmr <= TMR_ZERO;
			s_r.off_tmr <= OFF_CNT;
			s_r.blank_tmr <= TMR_ZERO;
			s_r.hic_cnt <= '0;
			s_r.hs_on <= 1'b0;
			s_r.hs_oe <= 1'b0;
			s_r.ls_on <= 1'b0;
			s_r.ls_oe <= 1'b0;
			s_r.ss_dis <= 1'b1;
			s_r.ref_int <= 1'b0;
			s_r.oc_fault <= 1'b0;
			s_r.pg_oe <= 1'b1;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state word
	assign hs_on = s_r.hs_on;
	assign hs_oe = s_r.hs_oe;
	assign ls_on = s_r.ls_on;
	assign ls_oe = s_r.ls_oe;
	assign ss_discharge = s_r.ss_dis;
	assign ref_internal = s_r.ref_int;
	assign overcurrent_fault = s_r.oc_fault;
	// open-drain: only ever drives low
	assign output_good_out = 1'b0; // R13
	assign output_good_oe = s_r.pg_oe; // R13

endmodule : bfsc_ctrl

/* tb/bfsc_ctrl_properties.sv */
// checker: timing properties of the buck fault shutdown control ports
`timescale 1ns/1ns
module bfsc_ctrl_properties
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// comparator levels
	input wire logic supply_ok,
	input wire logic enable_ok,
	input wire logic ss_low,
	input wire logic oc_below_gnd,
	input wire logic over_temp,
	input wire logic track_high,
	input wire logic fb_good,
	// drives and flags
	input wire logic hs_on,
	input wire logic hs_oe,
	input wire logic ls_on,
	input wire logic ls_oe,
	input wire logic ss_discharge,
	input wire logic ref_internal,
	input wire logic overcurrent_fault,
	input wire logic output_good_out,
	input wire logic output_good_oe
);
	// all properties share the block clock and reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	en_tristate_a: assert property (!enable_ok |-> ##3 !hs_oe && !ls_oe)
		else $error("drives not tristated after enable low");
	supply_clear_a: assert property (!supply_ok |-> ##3
		!overcurrent_fault && !hs_oe && !ls_oe)
		else $error("supply loss did not clear fault and drives");
	thermal_off_a: assert property ((over_temp && enable_ok && supply_ok)[*5]
		##0 hs_oe && $past(hs_oe) |-> !hs_on && !ls_on && ss_discharge)
		else $error("switches not off in over temperature");
	oc_blank_a: assert property ($rose(overcurrent_fault) |->
		$past(ls_on, 1) && $past(ls_on, 2) && $past(oc_below_gnd, 3))
		else $error("fault raised without sensed low side current");
	hiccup_entry_a: assert property ($rose(overcurrent_fault) |->
		ss_discharge && !hs_on && !ls_on)
		else $error("hiccup entry did not ground soft start");
	restart_off_a: assert property ($fell(overcurrent_fault) |->
		!hs_oe || !ls_on)
		else $error("restart after hiccup did not begin switched off");
	min_on_a: assert property ($fell(hs_on) && hs_oe && !ss_discharge
		&& !$past(ss_low, 3) |-> $past(hs_on, 2))
		else $error("high side pulse shorter than minimum");
	off_time_a: assert property ($fell(hs_on) |-> !hs_on[*5])
		else $error("high side off time too short");
	pg_low_a: assert property (!fb_good |-> ##3
		output_good_oe && !output_good_out)
		else $error("output good not pulled low");
	ref_follow_a: assert property (track_high |-> ##3 ref_internal)
		else $error("internal reference not selected");

	// main scenarios reached
	cover property ($rose(overcurrent_fault));
	cover property ($fell(hs_on));
	cover property ($fell(ss_discharge));
endmodule : bfsc_ctrl_properties

bind bfsc_ctrl bfsc_ctrl_properties u_bfsc_ctrl_properties (.clk, .rstn,
	.supply_ok, .enable_ok, .ss_low, .oc_below_gnd, .over_temp,
	.track_high, .fb_good, .hs_on, .hs_oe, .ls_on, .ls_oe, .ss_discharge,
	.ref_internal, .overcurrent_fault, .output_good_out, .output_good_oe);

/* tb/bfsc_stage_model.sv */
// model: power stage, soft-start node and comparators beside the block
`timescale 1ns/1ns
module bfsc_stage_model
(
	// clock
	input wire logic clk,
	// bench controls: outside soft-start pull and load fault
	input wire logic ss_pull,
	input wire logic overload,
	// drives from the block
	input wire logic ls_on,
	input wire logic ls_oe,
	input wire logic ss_discharge,
	input wire logic output_good_oe,
	// levels back to the block
	output logic osc,
	output logic ss_low,
	output logic ss_full,
	output logic oc_below_gnd,
	output logic output_good_in
);
	logic [2:0] div_r = 3'h0; // oscillator divider, eight clocks a cycle
	logic [3:0] lvl_r = 4'h0; // soft-start charge level

	// oscillator and soft-start capacitor charge
	always @(posedge clk)
	begin
		div_r <= div_r + 3'h1;
		if (ss_discharge || ss_pull)
			lvl_r <= 4'h0;
		else if (lvl_r != 4'hf)
			lvl_r <= lvl_r + 4'h1;
	end
	assign osc = div_r[2];
	assign ss_low = ss_pull;
	assign ss_full = (lvl_r == 4'hf);
	// sense node dips below ground only while the low side conducts
	assign oc_below_gnd = overload && ls_on && ls_oe;
	// pull-up on the open drain pin
	assign output_good_in = !output_good_oe;
endmodule : bfsc_stage_model

/* tb/bfsc_ctrl_test.sv */
// bench: directed scenarios for the buck fault shutdown control
`timescale 1ns/1ns
module bfsc_ctrl_test;
	logic clk = 1'b0, rstn = 1'b0, supply_ok = 1'b0, enable_ok = 1'b0;
	logic over_temp = 1'b0, track_high = 1'b0, fb_good = 1'b0;
	logic pwm_demand = 1'b0, ss_pull = 1'b0, overload = 1'b0;
	logic osc, ss_low, ss_full, oc_below_gnd, output_good_in;
	logic hs_on, hs_oe, ls_on, ls_oe, ss_discharge, ref_internal;
	logic overcurrent_fault, output_good_out, output_good_oe;
	int n_errors = 0;
	int num_checks = 0;

	// short hiccup count keeps the run brief
	bfsc_ctrl #(.HICCUP_LEN(8)) u_bfsc_ctrl (.clk, .rstn, .supply_ok,
		.enable_ok, .ss_low, .ss_full, .oc_below_gnd, .over_temp,
		.track_high, .fb_good, .pwm_demand, .osc, .hs_on, .hs_oe, .ls_on,
		.ls_oe, .ss_discharge, .ref_internal, .overcurrent_fault,
		.output_good_in, .output_good_out, .output_good_oe);
	bfsc_stage_model u_bfsc_stage_model (.clk, .ss_pull, .overload, .ls_on,
		.ls_oe, .ss_discharge, .output_good_oe, .osc, .ss_low, .ss_full,
		.oc_below_gnd, .output_good_in);

	// 25 MHz clock
	always #20 clk = ~clk;

	// compare and count
	task chk(input logic got, input logic exp);
		num_checks++;
		if (got !== exp)
			$display("ERROR %0t: got %b exp %b", $time, got, exp);
		if (got !== exp)
			n_errors++;
	endtask : chk

	// wait n edges, then let outputs settle
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	// bounded wait for the fault flag, counting the clock edges taken
	task wait_fault(input logic v, output int n);
		n = 0;
		while (n < 300 && overcurrent_fault !== v)
		begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask : wait_fault

	// one short demand pulse, then let the low side run
	task pulse;
		@(posedge clk);
		pwm_demand <= 1'b1;
		repeat (2) @(posedge clk);
		pwm_demand <= 1'b0;
		cyc(20);
	endtask : pulse

	// start-up, reference hand-over, long demand cut by the oscillator
	task t_start;
		chk(hs_oe, 1'b0);
		chk(output_good_in, 1'b0);
		chk(output_good_out, 1'b0);
		@(posedge clk);
		supply_ok <= 1'b1;
		enable_ok <= 1'b1;
		fb_good <= 1'b1;
		track_high <= 1'b1;
		cyc(4);
		chk(hs_oe, 1'b1);
		chk(ls_on, 1'b0);
		chk(output_good_in, 1'b1);
		chk(ref_internal, 1'b1);
		@(posedge clk);
		track_high <= 1'b0;
		pwm_demand <= 1'b1;
		cyc(4);
		chk(ref_internal, 1'b0);
		cyc(30);
		@(posedge clk);
		pwm_demand <= 1'b0;
		cyc(10);
		chk(ls_on, 1'b1);
	endtask : t_start

	// sense glitch inside the blanking time is ignored
	task t_blank;
		@(posedge clk);
		pwm_demand <= 1'b1;
		repeat (2) @(posedge clk);
		pwm_demand <= 1'b0;
		// the low side turns on four edges later: glitch for two cycles
		repeat (4) @(posedge clk);
		overload <= 1'b1;
		cyc(1);
		chk(oc_below_gnd, 1'b1);
		@(posedge clk);
		overload <= 1'b0;
		cyc(12);
		chk(overcurrent_fault, 1'b0);
	endtask : t_blank

	// overload, hiccup, restart and repeat
	task t_oc;
		int n;
		@(posedge clk);
		overload <= 1'b1;
		cyc(6);
		chk(overcurrent_fault, 1'b1);
		chk(ss_discharge, 1'b1);
		chk(ls_on, 1'b0);
		wait_fault(1'b0, n);
		// eight oscillator cycles of eight clocks, three edges already gone
		chk(n >= 54 && n <= 61, 1'b1);
		chk(ss_discharge, 1'b0);
		chk(ls_on, 1'b0);
		pulse;
		chk(overcurrent_fault, 1'b1);
		@(posedge clk);
		overload <= 1'b0;
		wait_fault(1'b0, n);
		chk(overcurrent_fault, 1'b0);
	endtask : t_oc

	// soft-start pull-down shutdown and resume
	task t_ss;
		pulse;
		@(posedge clk);
		ss_pull <= 1'b1;
		cyc(4);
		chk(hs_on, 1'b0);
		chk(ls_on, 1'b1);
		@(posedge clk);
		ss_pull <= 1'b0;
		cyc(4);
		chk(ls_on, 1'b0);
		cyc(25);
		pulse;
		chk(ls_on, 1'b1);
	endtask : t_ss

	// thermal trip, restart, then enable and supply loss
	task t_shut;
		@(posedge clk);
		over_temp <= 1'b1;
		cyc(4);
		chk(ls_on, 1'b0);
		chk(ss_discharge, 1'b1);
		@(posedge clk);
		over_temp <= 1'b0;
		cyc(5);
		chk(ss_discharge, 1'b0);
		@(posedge clk);
		over_temp <= 1'b1;
		enable_ok <= 1'b0;
		cyc(4);
		chk(hs_oe, 1'b0);
		chk(ls_oe, 1'b0);
		@(posedge clk);
		over_temp <= 1'b0;
		enable_ok <= 1'b1;
		overload <= 1'b1;
		cyc(4);
		pulse;
		chk(overcurrent_fault, 1'b1);
		@(posedge clk);
		supply_ok <= 1'b0;
		cyc(4);
		chk(overcurrent_fault, 1'b0);
		chk(hs_oe, 1'b0);
	endtask : t_shut

	// verdict and end of run
	task final_report;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	// main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		cyc(2);
		t_start;
		t_blank;
		t_oc;
		t_ss;
		t_shut;
		final_report;
	end

	// watchdog against a hang
	initial
	begin
		#200000;
		n_errors++;
		final_report;
	end
endmodule : bfsc_ctrl_test
